// ==== common/spi_dgram_pkg.sv ====
package spi_dgram_pkg;
  localparam int              FRAME_BITS   = 40;
  localparam int              ADDR_BITS    = 7;
  localparam int              DATA_BITS    = 32;
  localparam int              HDR_BITS     = 8;
  localparam int              WR_BIT       = 39;
  localparam int              CNT_W        = 6;
  localparam logic [5:0]      HDR_DONE_CNT = 6'h08;
  localparam logic [5:0]      FRAME_CNT    = 6'h28;
  localparam logic [7:0]      WR_FLAG      = 8'h80;
  localparam logic [7:0]      STATUS_RST   = 8'h00;
  localparam int              HALF_DIV     = 4;
endpackage

// ==== common/spi_dgram_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface spi_dgram_if;
  logic sclk;          // serial clock from host
  logic chip_select_n; // active-low frame select
  logic mosi;          // host to device data
  logic miso;          // device to host data
  modport device (input sclk, input chip_select_n, input mosi, output miso);
  modport host (output sclk, output chip_select_n, output mosi, input miso);
endinterface
`default_nettype wire

// ==== src/spi_dgram_device.sv ====
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - every frame is exactly forty bits
// - host holds select low whole frame
// - address byte then 32-bit data word
// - full 32 data bits for every access
// - bit 39 set means write
// - device always shifts response data out
// - host discards data returned on writes
// - read fetched once address byte arrives
// - read frame data bits are ignored
// - short values right aligned in data
// - signed fields two's complement, else binary
// - most significant bit travels first
// - sample on rising, drive after falling
// - select rise commits the write
module spi_dgram_device
  import spi_dgram_pkg::*;
(
  input  wire logic                 ref_clk,    // system clock
  input  wire logic                 resetn,     // async reset, active low
  spi_dgram_if.device               link,       // serial pins
  output logic [ADDR_BITS-1:0]      rd_addr,    // register read address
  output logic                      rd_req,     // read fetch pulse
  input  wire logic [DATA_BITS-1:0] rd_data,    // fetched register value
  output logic [ADDR_BITS-1:0]      wr_addr,    // committed write address
  output logic [DATA_BITS-1:0]      wr_data,    // committed write data
  output logic                      wr_strobe   // write commit pulse
);
  logic [2:0]            sck_q, sck_d;     // sclk sync and history
  logic [2:0]            cs_q, cs_d;       // select sync and history
  logic [1:0]            di_q, di_d;       // data-in sync
  logic [FRAME_BITS-1:0] rx_q, rx_d;       // received frame
  logic [DATA_BITS-1:0]  tx_q, tx_d;       // fetched word going out
  logic [HDR_BITS-1:0]   stat_q, stat_d;   // status byte going out
  logic [HDR_BITS-1:0]   prev_q, prev_d;   // latest address byte
  logic [CNT_W-1:0]      cnt_q, cnt_d;     // rises seen in frame
  logic                  miso_q, miso_d;   // serial output flop
  logic                  fetch_q, fetch_d; // address byte complete
  logic [ADDR_BITS-1:0]  ra_q, ra_d;       // read address
  logic                  rr_q, rr_d;       // read request
  logic [ADDR_BITS-1:0]  wa_q, wa_d;       // write address
  logic [DATA_BITS-1:0]  wd_q, wd_d;       // write data
  logic                  ws_q, ws_d;       // write strobe
  logic                  rise, fall;       // sclk edges
  logic                  cs_rise, cs_low;  // select edge and level

  // next rise count, shared by shifter and fetch trigger
  function automatic logic [CNT_W-1:0] count_up(input logic [CNT_W-1:0] c);
    return c + 6'h01;
  endfunction

  // pin stages 0,1 synchronise; stage 2 is history for edge find
  always_comb
  begin
    sck_d = {sck_q[1:0], link.sclk};
    cs_d  = {cs_q[1:0], link.chip_select_n};
    di_d  = {di_q[0], link.mosi};
  end

  // edges and level seen only behind the second flop
  assign rise    = sck_q[1] & ~sck_q[2];
  assign fall    = ~sck_q[1] & sck_q[2];
  assign cs_low  = ~cs_q[1];
  assign cs_rise = cs_q[1] & ~cs_q[2];

  // synchroniser registers; idle levels at reset avoid a false edge
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sck_q <= '1;
      cs_q  <= '1;
      di_q  <= '0;
    end
    else
    begin
      sck_q <= sck_d;
      cs_q  <= cs_d;
      di_q  <= di_d;
    end
  end

  // serial side: shift in on rise, shift out after fall, fetch trigger;
  // the pins arrive two flops late, so the answer leaves about three
  // system clocks after the host's fall and the host must allow for it
  always_comb
  begin
    rx_d    = rx_q;
    tx_d    = tx_q;
    cnt_d   = cnt_q;
    miso_d  = miso_q;
    stat_d  = stat_q;
    fetch_d = 1'b0;
    if (!cs_low)
    begin
      cnt_d  = '0;
      tx_d   = '0;
      miso_d = prev_q[HDR_BITS-1];               // first bit at select
      stat_d = prev_q;
    end
    else if (rise)
    begin
      rx_d  = {rx_q[FRAME_BITS-2:0], di_q[1]};
      cnt_d = count_up(cnt_q);
      if (count_up(cnt_q) == HDR_DONE_CNT)
        fetch_d = 1'b1;
    end
    else if (fall && cnt_q != '0)
    begin
      // the first fall keeps the bit put out at select; each later fall
      // moves on to the bit that the next rise samples
      if (cnt_q < HDR_DONE_CNT)
      begin
        stat_d = {stat_q[HDR_BITS-2:0], 1'b0};   // status byte
        miso_d = stat_q[HDR_BITS-2];
      end
      else if (cnt_q == HDR_DONE_CNT)
        miso_d = tx_q[DATA_BITS-1];
      else
      begin
        tx_d   = {tx_q[DATA_BITS-2:0], 1'b0};
        miso_d = tx_q[DATA_BITS-2];
      end
    end
    if (rr_q)
      tx_d = rd_data;                            // value as-is
  end

  // serial side registers
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_q    <= '0;
      tx_q    <= '0;
      cnt_q   <= '0;
      miso_q  <= 1'b0;
      stat_q  <= STATUS_RST;
      fetch_q <= 1'b0;
    end
    else
    begin
      rx_q    <= rx_d;
      tx_q    <= tx_d;
      cnt_q   <= cnt_d;
      miso_q  <= miso_d;
      stat_q  <= stat_d;
      fetch_q <= fetch_d;
    end
  end

  // register side: fetch on the address byte, commit at select rise
  always_comb
  begin
    prev_d = prev_q;
    ra_d   = ra_q;
    rr_d   = 1'b0;
    wa_d   = wa_q;
    wd_d   = wd_q;
    ws_d   = 1'b0;
    if (fetch_q)
    begin
      ra_d   = rx_q[ADDR_BITS-1:0];
      rr_d   = 1'b1;
      prev_d = rx_q[HDR_BITS-1:0];
    end
    // a cut or overlong frame is dropped, and a read never writes
    if (cs_rise && cnt_q == FRAME_CNT && rx_q[WR_BIT])
    begin
      wa_d = rx_q[DATA_BITS+ADDR_BITS-1:DATA_BITS];
      wd_d = rx_q[DATA_BITS-1:0];
      ws_d = 1'b1;
    end
  end

  // register side registers
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      prev_q <= STATUS_RST;
      ra_q   <= '0;
      rr_q   <= 1'b0;
      wa_q   <= '0;
      wd_q   <= '0;
      ws_q   <= 1'b0;
    end
    else
    begin
      prev_q <= prev_d;
      ra_q   <= ra_d;
      rr_q   <= rr_d;
      wa_q   <= wa_d;
      wd_q   <= wd_d;
      ws_q   <= ws_d;
    end
  end
  assign link.miso = miso_q;
  assign rd_addr   = ra_q;
  assign rd_req    = rr_q;
  assign wr_addr   = wa_q;
  assign wr_data   = wd_q;
  assign wr_strobe = ws_q;
endmodule
`default_nettype wire

// ==== src/spi_dgram_host.sv ====
`timescale 1ns/10ps
`default_nettype none
module spi_dgram_host
  import spi_dgram_pkg::*;
(
  input  wire logic                 ref_clk,   // system clock
  input  wire logic                 resetn,    // async reset, active low
  spi_dgram_if.host                 link,      // serial pins
  input  wire logic                 start,     // begin frame pulse
  input  wire logic                 write,     // direction of frame
  input  wire logic [ADDR_BITS-1:0] addr,      // register address
  input  wire logic [DATA_BITS-1:0] wdata,     // data to write
  output logic                      busy,      // frame in progress
  output logic                      done,      // frame finished pulse
  output logic [DATA_BITS-1:0]      rdata,     // read result
  output logic [HDR_BITS-1:0]       status     // status byte
);
  typedef enum logic [1:0] {IDLE = 2'b00, SHIFT = 2'b01, ENDF = 2'b11} st_t;
  st_t                   st_q, st_d;
  logic [FRAME_BITS-1:0] sh_q, sh_d, in_q, in_d;
  logic [CNT_W-1:0]      cnt_q, cnt_d;
  logic [2:0]            div_q, div_d;
  logic [1:0]            mi_q, mi_d;
  logic                  sck_q, sck_d, cs_q, cs_d, wr_q, wr_d, dn_q, dn_d;
  logic [DATA_BITS-1:0]  rd_q, rd_d;
  logic [HDR_BITS-1:0]   stq_q, stq_d;
  logic                  bz_q, bz_d;

  // mode 3 master: sclk idles high, divider gives 8-cycle bit time;
  // mosi moves after every fall but the first, so it stands at the rise;
  // miso is taken half a bit after each rise, because the slave answers
  // through its synchroniser and ours about five clocks after a fall
  always_comb
  begin
    st_d  = st_q;
    sh_d  = sh_q;
    in_d  = in_q;
    cnt_d = cnt_q;
    div_d = div_q;
    sck_d = sck_q;
    cs_d  = cs_q;
    wr_d  = wr_q;
    dn_d  = 1'b0;
    rd_d  = rd_q;
    stq_d = stq_q;
    mi_d  = {mi_q[0], link.miso};
    unique case (st_q)
      IDLE:
        if (start)
        begin
          sh_d  = {(write ? WR_FLAG : 8'h00) | {1'b0, addr},
                   write ? wdata : 32'h0};
          wr_d  = write;
          cs_d  = 1'b0;
          cnt_d = '0;
          div_d = '0;
          st_d  = SHIFT;
        end
      SHIFT:
      begin
        div_d = div_q + 3'h1;
        if (div_q == 3'(HALF_DIV - 1))
        begin
          sck_d = 1'b0;                           // falling edge
          if (cnt_q != '0)
          begin
            sh_d = {sh_q[FRAME_BITS-2:0], 1'b0};
            in_d = {in_q[FRAME_BITS-2:0], mi_q[1]};
          end
        end
        if (div_q == 3'(2 * HALF_DIV - 1))
        begin
          sck_d = 1'b1;                           // rising edge
          cnt_d = cnt_q + 6'h01;
          if (cnt_q + 6'h01 == FRAME_CNT)
            st_d = ENDF;
        end
      end
      ENDF:
      begin
        div_d = div_q + 3'h1;
        if (div_q == 3'(HALF_DIV - 1))
        begin
          in_d  = {in_q[FRAME_BITS-2:0], mi_q[1]};  // last bit
          cs_d  = 1'b1;
          dn_d  = 1'b1;
          st_d  = IDLE;
          stq_d = in_d[FRAME_BITS-1:DATA_BITS];
          if (!wr_q)
            rd_d = in_d[DATA_BITS-1:0];
        end
      end
      default: st_d = IDLE;
    endcase
    bz_d = ~cs_d;
  end

  // state registers
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_q  <= IDLE;
      sh_q  <= '0;
      in_q  <= '0;
      cnt_q <= '0;
      div_q <= '0;
      sck_q <= 1'b1;
      cs_q  <= 1'b1;
      wr_q  <= 1'b0;
      dn_q  <= 1'b0;
      rd_q  <= '0;
      stq_q <= '0;
      mi_q  <= '0;
      bz_q  <= 1'b0;
    end
    else
    begin
      st_q  <= st_d;
      sh_q  <= sh_d;
      in_q  <= in_d;
      cnt_q <= cnt_d;
      div_q <= div_d;
      sck_q <= sck_d;
      cs_q  <= cs_d;
      wr_q  <= wr_d;
      dn_q  <= dn_d;
      rd_q  <= rd_d;
      stq_q <= stq_d;
      mi_q  <= mi_d;
      bz_q  <= bz_d;
    end
  end
  assign link.sclk          = sck_q;
  assign link.chip_select_n = cs_q;
  assign link.mosi          = sh_q[FRAME_BITS-1];
  assign busy   = bz_q;
  assign done   = dn_q;
  assign rdata  = rd_q;
  assign status = stq_q;
endmodule
`default_nettype wire

// ==== sim/spi_dgram_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
module spi_dgram_monitor
  import spi_dgram_pkg::*;
(
  input wire logic ref_clk,       // system clock
  input wire logic resetn,        // async reset, active low
  input wire logic sclk,          // serial clock
  input wire logic chip_select_n, // frame select
  input wire logic mosi,          // host data
  input wire logic miso           // device data
);
  logic [5:0] cnt_q, cnt_d; // rises seen in frame
  logic [7:0] hdr_q, hdr_d; // address byte of frame
  logic [7:0] prv_q, prv_d; // address byte of last frame
  logic       sck_q;        // delayed serial clock
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // count rises, gather address byte, keep it at frame end
  always_comb
  begin
    cnt_d = cnt_q;
    hdr_d = hdr_q;
    prv_d = prv_q;
    if (chip_select_n)
      cnt_d = 6'h00;
    else if (sclk && !sck_q)
      cnt_d = cnt_q + 6'h01;
    if (!chip_select_n && sclk && !sck_q && cnt_q < HDR_DONE_CNT)
      hdr_d = {hdr_q[6:0], mosi};
    if (chip_select_n && cnt_q == FRAME_CNT)
      prv_d = hdr_q;
  end
  // helper registers
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_q <= 6'h00;
      hdr_q <= 8'h00;
      prv_q <= STATUS_RST;
      sck_q <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_d;
      hdr_q <= hdr_d;
      prv_q <= prv_d;
      sck_q <= sclk;
    end
  end
  property p_idle; chip_select_n |-> sclk; endproperty
  a_idle: assert property (p_idle) else $error("clock not idle high");
  property p_cnt; $rose(chip_select_n) |-> cnt_q == FRAME_CNT; endproperty
  a_cnt: assert property (p_cnt) else $error("frame not 40 bits");
  property p_max; !chip_select_n |-> cnt_q <= FRAME_CNT; endproperty
  a_max: assert property (p_max) else $error("frame too long");
  property p_half; $changed(sclk) |=> $stable(sclk) [*3]; endproperty
  a_half: assert property (p_half) else $error("clock phase short");
  property p_setup; $rose(sclk) |-> $stable(mosi); endproperty
  a_setup: assert property (p_setup) else $error("mosi moved");
  property p_miso;
    !chip_select_n && cnt_q != 6'h00 && $changed(miso) |-> !sclk;
  endproperty
  a_miso: assert property (p_miso) else $error("miso moved high");
  property p_stat;
    $rose(sclk) && !chip_select_n && cnt_q < HDR_DONE_CNT
      |-> miso == prv_q[3'h7 - cnt_q[2:0]];
  endproperty
  a_stat: assert property (p_stat) else $error("bad status bit");
  property p_len; $fell(chip_select_n) |-> ##[300:400] $rose(chip_select_n);
  endproperty
  a_len: assert property (p_len) else $error("select not held");
  c_wr: cover property ($rose(chip_select_n) && hdr_q[7]);
  c_rd: cover property ($rose(chip_select_n) && !hdr_q[7]);
  c_end: cover property ($rose(sclk) && cnt_q == 6'h27);
endmodule
`default_nettype wire

// ==== sim/spi_register_datagram_port_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module spi_register_datagram_port_tb
  import spi_dgram_pkg::*;
;
  logic        ref_clk, resetn, start, write, busy, done, rd_req, wr_strobe;
  logic [6:0]  addr, rd_addr, wr_addr;
  logic [31:0] wdata, rdata, rd_data, wr_data, last_rd;
  logic [31:0] regs [128];
  logic [7:0]  status, last_hdr;
  int          error_cnt, tests_run, nwr, nrd;
  spi_dgram_if link ();
  spi_dgram_device spi_dgram_device_i (.ref_clk(ref_clk), .resetn(resetn),
    .link(link), .rd_addr(rd_addr), .rd_req(rd_req), .rd_data(rd_data),
    .wr_addr(wr_addr), .wr_data(wr_data), .wr_strobe(wr_strobe));
  spi_dgram_host spi_dgram_host_i (.ref_clk(ref_clk), .resetn(resetn),
    .link(link), .start(start), .write(write), .addr(addr), .wdata(wdata),
    .busy(busy), .done(done), .rdata(rdata), .status(status));
  spi_dgram_monitor spi_dgram_monitor_i (.ref_clk(ref_clk),
    .resetn(resetn), .sclk(link.sclk), .chip_select_n(link.chip_select_n),
    .mosi(link.mosi), .miso(link.miso));
  // register file behind the device
  assign rd_data = regs[rd_addr];
  always @(posedge ref_clk)
  begin
    if (wr_strobe === 1'b1)
    begin
      regs[wr_addr] <= wr_data;
      nwr <= nwr + 1;
    end
    if (rd_req === 1'b1)
      nrd <= nrd + 1;
  end
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", n, exp, got);
    end
  endtask
  // one frame from the host side, waits for done
  task automatic xfer(input logic w, input logic [6:0] a,
                      input logic [31:0] d);
    int n;
    int r0;
    r0 = nrd;
    start <= 1'b1;
    write <= w;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    start <= 1'b0;
    #1;
    chk("busy", {31'h0, busy}, 32'h1);
    n = 0;
    do
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    while (done !== 1'b1 && n < 1000);
    if (n >= 1000)
    begin
      error_cnt++;
      end_of_test();
    end
    chk("status", {24'h0, status}, {24'h0, last_hdr});
    chk("idle", {31'h0, busy}, 32'h0);
    chk("rd_req", nrd, r0 + 1);
    last_hdr = {w, a};
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    int n0;
    int k;
    n0 = nwr;
    xfer(1'b1, a, d);
    for (k = 0; k < 20 && nwr == n0; k++)
      @(posedge ref_clk);
    chk("wr_cnt", nwr, n0 + 1);
    chk("wr_addr", {25'h0, wr_addr}, {25'h0, a});
    chk("wr_data", wr_data, d);
    chk("rdata_kept", rdata, last_rd);
  endtask
  // read hands the host junk data, which the frame sends as zeros; nothing must be written
  task automatic rd(input logic [6:0] a, input logic [31:0] e);
    int n0;
    n0 = nwr;
    xfer(1'b0, a, 32'hdeadbeef);
    repeat (8) @(posedge ref_clk);
    chk("no_wr", nwr, n0);
    chk("rdata", rdata, e);
    last_rd = e;
  endtask
  initial
  begin
    resetn = 1'b0;
    start = 1'b0;
    write = 1'b0;
    addr = 7'h00;
    wdata = 32'h0;
    error_cnt = 0;
    tests_run = 0;
    nwr = 0;
    nrd = 0;
    last_rd = 32'h0;
    last_hdr = STATUS_RST;
    for (int i = 0; i < 128; i++)
      regs[i] = 32'h0;
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd(7'h00, 32'h0);
    wr(7'h01, 32'h00000010);
    wr(7'h7f, 32'hfffffff6);
    rd(7'h01, 32'h00000010);
    rd(7'h7f, 32'hfffffff6);
    wr(7'h00, 32'h80000001);
    rd(7'h00, 32'h80000001);
    end_of_test();
  end
endmodule
`default_nettype wire
